// ===== src/boc_pkg.sv
/*
  Shared constants and types for the overcurrent and start-up controller.
  Assumes a single 125 MHz clock; all times are converted here to cycles.
*/
package boc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ       = 125000;
	localparam int DELAY_US      = 6800;                      // Init delay and soft-start
	localparam int DELAY_CYC     = DELAY_US * (CLK_KHZ / 1000);
	localparam int SS_STEPS      = 64;                        // Discrete ramp steps
	localparam int SS_STEP_CYC   = DELAY_CYC / SS_STEPS;
	localparam int DUMMY_COUNT   = 2;                         // Dummy time-outs per hiccup
	localparam int BLANK_NS      = 200;                       // Window opening delay
	localparam int BLANK_CYC     = (BLANK_NS * CLK_KHZ + 999999) / 1000000;
	localparam int MINLS_NS      = 425;                       // Minimum low-side width
	localparam int MINLS_CYC     = (MINLS_NS * CLK_KHZ + 999999) / 1000000;
	localparam int SW_KHZ        = 600;                       // Switching rate
	localparam int SW_PERIOD_CYC = CLK_KHZ / SW_KHZ;
	localparam int NARROW_LIMIT  = 3;                         // Narrow pulse that gets stretched (two narrow before it)

	// ----------------------------------------------------------------
	// Trip setpoint sampling
	// ----------------------------------------------------------------
	localparam int TRIP_W          = 8;
	localparam int TRIP_LSB_UV     = 1250;                    // Setpoint microvolts per code
	localparam int OCP_OFF_MV      = 300;                     // Setpoint that disables guard
	localparam int OCP_OFF_CODE    = OCP_OFF_MV * 1000 / TRIP_LSB_UV;
	localparam int DETECT_MAX_MV   = 475;                     // Doubled threshold ceiling
	localparam int DETECT_MAX_CODE = DETECT_MAX_MV * 1000 / TRIP_LSB_UV;
	localparam int SAMPLE_MAX_US   = 3400;
	localparam int SAMPLE_STEP_CYC = SAMPLE_MAX_US * (CLK_KHZ / 1000) / OCP_OFF_CODE;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		BOC_OFF    = 6'b000001,
		BOC_DELAY  = 6'b000010,
		BOC_SAMPLE = 6'b000100,
		BOC_SOFT   = 6'b001000,
		BOC_RUN    = 6'b010000,
		BOC_DUMMY  = 6'b100000
	} boc_state_e;

	typedef struct packed {
		logic              valid;     // A sample has completed
		logic              disabled;  // Setpoint too high, guard off
		logic [TRIP_W-1:0] code;      // Held setpoint
	} boc_trip_s;

	typedef struct packed {
		logic hs_en;  // High-side switch allowed
		logic ls_en;  // Low-side switch allowed
	} boc_gate_s;

endpackage

// ===== src/boc_sample_hold.sv
/*
  Counter and DAC that sample the trip setpoint once and hold it.
  Assumes set_cmp_in is high once the DAC level reaches the pin voltage.
*/
`timescale 1ns/100ps
module boc_sample_hold
	import boc_pkg::*;
#(
	parameter int P_STEP_CYC = SAMPLE_STEP_CYC
) (
	input  wire logic      clk_in,
	input  wire logic      rst_in,
	input  wire logic      ce_in,
	input  wire logic      start_in,      // One-cycle pulse: begin a fresh sample
	input  wire logic      set_cmp_in,    // DAC has reached trip_set_pin level
	output logic           isrc_en_out,   // Current source into trip_resistor
	output logic           done_out,      // One-cycle pulse at sample end
	output boc_trip_s      trip_out
);

	if (P_STEP_CYC < 1 || P_STEP_CYC >= (1 << 16)) begin : g_chk
		$error("P_STEP_CYC out of range for the 16-bit step timer");
	end

	typedef struct packed {
		logic        busy;
		logic        done;
		logic [15:0] tmr;
		boc_trip_s   trip;
	} boc_sh_s;

	boc_sh_s s_r;
	boc_sh_s s_nxt;

	// ----------------------------------------------------------------
	// Sample sequencing
	// ----------------------------------------------------------------
	// Ramp the counter until the comparator trips or the off code is hit
	always_comb begin
		s_nxt      = s_r;
		s_nxt.done = 1'b0;
		if (start_in) begin
			s_nxt.busy = 1'b1;
			s_nxt.tmr  = '0;
			s_nxt.trip = '0;
		end else if (s_r.busy) begin
			if (s_r.tmr == 16'(P_STEP_CYC - 1)) begin
				s_nxt.tmr = '0;
				if (set_cmp_in || s_r.trip.code == TRIP_W'(OCP_OFF_CODE)) begin
					s_nxt.busy          = 1'b0;
					s_nxt.done          = 1'b1;
					s_nxt.trip.valid    = 1'b1;
					s_nxt.trip.disabled = (s_r.trip.code == TRIP_W'(OCP_OFF_CODE));
				end else begin
					s_nxt.trip.code = s_r.trip.code + 1'b1;
				end
			end else begin
				s_nxt.tmr = s_r.tmr + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_r <= '0;
		end else if (ce_in) begin
			s_r <= s_nxt;
		end
	end

	assign isrc_en_out = s_r.busy;
	assign done_out    = s_r.done;
	assign trip_out    = s_r.trip;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	a_code_held: assert property (!s_r.busy && !start_in && ce_in |=> $stable(s_r.trip.code))
		else $error("held setpoint changed without a new sample");
	a_off_code: assert property (done_out && trip_out.code == TRIP_W'(OCP_OFF_CODE)
		|-> trip_out.disabled)
		else $error("setpoint above limit did not disable guard");

endmodule

// ===== src/boc_ls_monitor.sv
/*
  Low-side gate shaping, blanked monitoring window and minimum-width stretch.
  Assumes pwm_low_in and ls_cmp_in are synchronous to clk_in.
*/
`timescale 1ns/100ps
module boc_ls_monitor
	import boc_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic ce_in,
	input  wire logic allow_in,     // Low-side switching permitted
	input  wire logic arm_in,       // Guard armed
	input  wire logic pwm_low_in,   // Internal PWM low-side request
	input  wire logic ls_cmp_in,    // Switch drop above doubled setpoint
	output logic      ls_gate_out,
	output logic      window_out,
	output logic      ocp_flag_out
);

	typedef struct packed {
		logic       gate;
		logic       stretch;
		logic       pulse_ok;
		logic [1:0] narrow;
		logic [7:0] on_cnt;
		logic [7:0] per_cnt;
		logic       overcurrent_guard;
	} boc_lsm_s;

	boc_lsm_s s_r;
	boc_lsm_s s_nxt;
	logic     window;
	logic     force_3rd;

	assign window    = s_r.gate && (s_r.on_cnt >= 8'(BLANK_CYC));
	assign force_3rd = (s_r.narrow == 2'(NARROW_LIMIT - 1));

	// ----------------------------------------------------------------
	// Gate, window and stretch
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		// Switching period and narrow-pulse count
		if (s_r.per_cnt == 8'(SW_PERIOD_CYC - 1)) begin
			s_nxt.per_cnt  = '0;
			s_nxt.pulse_ok = 1'b0;
			s_nxt.narrow   = s_r.pulse_ok ? 2'b00 :
				(force_3rd ? 2'b00 : s_r.narrow + 1'b1);
		end else begin
			s_nxt.per_cnt = s_r.per_cnt + 1'b1;
		end
		if (s_r.gate && s_r.on_cnt >= 8'(MINLS_CYC - 1)) begin
			s_nxt.pulse_ok = 1'b1;
		end
		if (force_3rd && allow_in && !s_r.gate && !s_r.pulse_ok &&
			(pwm_low_in || s_r.per_cnt == 8'(SW_PERIOD_CYC - MINLS_CYC - 1))) begin
			s_nxt.stretch = 1'b1;
		end else if (!allow_in || (s_r.gate && s_r.on_cnt >= 8'(MINLS_CYC - 1))) begin
			s_nxt.stretch = 1'b0;
		end
		s_nxt.gate   = allow_in && (pwm_low_in || s_nxt.stretch);
		s_nxt.on_cnt = !s_r.gate ? 8'h00 :
			(s_r.on_cnt == 8'hff ? s_r.on_cnt : s_r.on_cnt + 1'b1);
		s_nxt.overcurrent_guard = window && ls_cmp_in && arm_in;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_r <= '0;
		end else if (ce_in) begin
			s_r <= s_nxt;
		end
	end

	assign ls_gate_out  = s_r.gate;
	assign window_out   = window;
	assign ocp_flag_out = s_r.overcurrent_guard;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	a_window_blank: assert property (window_out |-> s_r.on_cnt >= 8'(BLANK_CYC) && ls_gate_out)
		else $error("window open before blanking time");
	a_window_start: assert property ($rose(ls_gate_out) |-> !window_out [*8])
		else $error("window opened right at gate rise");
	a_flag_cause: assert property (window_out && ls_cmp_in && arm_in && ce_in |=> ocp_flag_out)
		else $error("overcurrent in window not flagged");
	a_stretch_min: assert property ($fell(s_r.stretch) && $past(allow_in) && $past(ce_in)
		|-> $past(s_r.on_cnt) >= 8'(MINLS_CYC - 1))
		else $error("stretched pulse ended early");

endmodule

// ===== src/boc_ctrl.sv
/*
  Start-up and hiccup sequencer for a step-down module, with soft-start ramp.
  Assumes all pin inputs are synchronous to clk_in and analog levels arrive as
  comparator bits; the analog loop compares the switch drop with trip_thresh_out.
*/
// What this block does
// - Pre-biased high output: switches off until ramp end
// - Re-enable reruns full init with fresh sample
// - Retries reuse stored setpoint, no resample
// - Trip: output off, two dummies, one attempt
// - Hiccup repeats without limit while shorted
// - After delay, low-side off, current source on
// - Setpoint held in counter DAC without decay
// - Window opens 200ns after rise, ends at fall
// - Three narrow pulses: third stretched to 425ns
// - Threshold is twice the stored setpoint, clamped at 475mV
// - Range 0 to 475mV, above 0.3V disables
// - Hiccup period 13.6ms to 20.4ms nominal
// - Short removed: next attempt ramps normally
// - Guard armed during soft-start, same hiccup
// - Trip in attempt restarts dummy pair
// - Soft-start reference in 64 steps
// - Timers independent of 600kHz switching rate
// - Shutdown until enable pin above trip point
`timescale 1ns/100ps
module boc_ctrl
	import boc_pkg::*;
#(
	parameter int P_DELAY_CYC   = DELAY_CYC,
	parameter int P_SS_STEP_CYC = SS_STEP_CYC,
	parameter int P_SAMPLE_STEP = SAMPLE_STEP_CYC
) (
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	input  wire logic              ce_in,
	input  wire logic              power_ok_in,     // Bias supply above rising threshold
	input  wire logic              enable_in,       // Enable pin above trip point
	input  wire logic              set_cmp_in,      // Sample DAC reached trip_set_pin
	input  wire logic              vout_above_in,   // Output above soft-start reference
	input  wire logic              pwm_high_in,     // Internal PWM high-side request
	input  wire logic              pwm_low_in,      // Internal PWM low-side request
	input  wire logic              ls_cmp_in,       // Switch drop above trip_thresh_out
	output logic                   hs_gate_out,
	output logic                   ls_gate_out,
	output logic                   isrc_en_out,
	output logic [5:0]             ss_ref_out,
	output logic [TRIP_W-1:0]      trip_code_out,
	output logic [TRIP_W:0]        trip_thresh_out,
	output logic                   guard_off_out,
	output logic                   hiccup_out,
	output logic                   running_out
);

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	if (P_DELAY_CYC < 1 || P_DELAY_CYC >= (1 << 20)) begin : g_chk_delay
		$error("P_DELAY_CYC out of range");
	end
	if (P_SS_STEP_CYC < 1 || P_SS_STEP_CYC >= (1 << 20)) begin : g_chk_step
		$error("P_SS_STEP_CYC out of range");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		boc_state_e  st;
		logic [19:0] tmr;
		logic [5:0]  step;
		logic        dummy_n;   // Dummy time-outs already done
		logic        sw_on;     // Switching released in this attempt
		logic        samp_go;
	} boc_ctrl_s;

	boc_ctrl_s  s_r;
	boc_ctrl_s  s_nxt;
	boc_trip_s  trip;
	boc_gate_s  gate;
	logic       samp_done;
	logic       ocp_flag;
	logic       arm;
	logic       step_tick;
	logic       ramp_done;

	// Decoding used for gating and for the checks below
	function automatic logic is_active(input boc_state_e st);
		return (st == BOC_SOFT) || (st == BOC_RUN);
	endfunction

	assign step_tick = (s_r.tmr == 20'(P_SS_STEP_CYC - 1));
	assign ramp_done = step_tick && (s_r.step == 6'(SS_STEPS - 1));
	assign arm       = is_active(s_r.st) && trip.valid && !trip.disabled;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt         = s_r;
		s_nxt.samp_go = 1'b0;
		case (s_r.st)
			BOC_OFF: begin
				s_nxt.tmr = '0;
				if (power_ok_in && enable_in) begin
					s_nxt.st = BOC_DELAY;
				end
			end
			BOC_DELAY: begin
				s_nxt.tmr = s_r.tmr + 1'b1;
				if (s_r.tmr == 20'(P_DELAY_CYC - 1)) begin
					s_nxt.st      = BOC_SAMPLE;
					s_nxt.tmr     = '0;
					s_nxt.samp_go = 1'b1;
				end
			end
			BOC_SAMPLE: begin
				if (samp_done) begin
					s_nxt.st    = BOC_SOFT;
					s_nxt.step  = '0;
					s_nxt.tmr   = '0;
					s_nxt.sw_on = 1'b0;
				end
			end
			BOC_SOFT: begin
				s_nxt.tmr  = step_tick ? 20'h00000 : s_r.tmr + 1'b1;
				s_nxt.step = step_tick ? s_r.step + 1'b1 : s_r.step;
				// hold off while output above ramp
				if (!vout_above_in) begin
					s_nxt.sw_on = 1'b1;
				end
				if (ocp_flag) begin
					s_nxt.st      = BOC_DUMMY;
					s_nxt.dummy_n = 1'b0;
					s_nxt.step    = '0;
					s_nxt.tmr     = '0;
				end else if (ramp_done) begin
					s_nxt.st = BOC_RUN;
				end
			end
			BOC_RUN: begin
				if (ocp_flag) begin
					s_nxt.st      = BOC_DUMMY;
					s_nxt.dummy_n = 1'b0;
					s_nxt.step    = '0;
					s_nxt.tmr     = '0;
				end
			end
			BOC_DUMMY: begin
				s_nxt.tmr  = step_tick ? 20'h00000 : s_r.tmr + 1'b1;
				s_nxt.step = step_tick ? s_r.step + 1'b1 : s_r.step;
				if (ramp_done) begin
					s_nxt.step = '0;
					s_nxt.tmr  = '0;
					if (s_r.dummy_n == 1'(DUMMY_COUNT - 1)) begin
						s_nxt.st    = BOC_SOFT;
						s_nxt.sw_on = 1'b0;
					end else begin
						s_nxt.dummy_n = 1'b1;
					end
				end
			end
			default: begin
				s_nxt.st = BOC_OFF;
			end
		endcase
		if (!power_ok_in || !enable_in) begin
			s_nxt.st      = BOC_OFF;
			s_nxt.tmr     = '0;
			s_nxt.step    = '0;
			s_nxt.dummy_n = 1'b0;
			s_nxt.sw_on   = 1'b0;
			s_nxt.samp_go = 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_r <= '{st: BOC_OFF, tmr: '0, step: '0, dummy_n: 1'b0,
				sw_on: 1'b0, samp_go: 1'b0};
		end else if (ce_in) begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Setpoint store and low-side monitor
	// ----------------------------------------------------------------
	boc_sample_hold #(
		.P_STEP_CYC (P_SAMPLE_STEP)
	) u_sample (
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.ce_in       (ce_in),
		.start_in    (s_r.samp_go),
		.set_cmp_in  (set_cmp_in),
		.isrc_en_out (isrc_en_out),
		.done_out    (samp_done),
		.trip_out    (trip)
	);

	// trip flag drops high-side gate at once, low-side gate at next edge
	assign gate.hs_en = ((s_r.st == BOC_RUN) || (s_r.st == BOC_SOFT && s_r.sw_on)) && !ocp_flag;
	assign gate.ls_en = gate.hs_en;

	boc_ls_monitor u_lsmon (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.ce_in        (ce_in),
		.allow_in     (gate.ls_en),
		.arm_in       (arm),
		.pwm_low_in   (pwm_low_in),
		.ls_cmp_in    (ls_cmp_in),
		.ls_gate_out  (ls_gate_out),
		.window_out   (),
		.ocp_flag_out (ocp_flag)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign hs_gate_out   = gate.hs_en && pwm_high_in && !ls_gate_out;
	assign ss_ref_out    = (s_r.st == BOC_SOFT) ? s_r.step :
		((s_r.st == BOC_RUN) ? 6'h3f : 6'h00);
	assign trip_code_out = trip.code;
	assign trip_thresh_out = ({trip.code, 1'b0} > (TRIP_W + 1)'(DETECT_MAX_CODE)) ?
		(TRIP_W + 1)'(DETECT_MAX_CODE) : {trip.code, 1'b0};
	assign guard_off_out = trip.disabled;
	assign hiccup_out    = (s_r.st == BOC_DUMMY);
	assign running_out   = (s_r.st == BOC_RUN);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence s_trip_seen;
		is_active(s_r.st) && ocp_flag && power_ok_in && enable_in && ce_in;
	endsequence
	sequence s_retry_start;
		s_r.st == BOC_DUMMY ##1 s_r.st == BOC_SOFT;
	endsequence

	a_trip_off: assert property (s_trip_seen |=> s_r.st == BOC_DUMMY && !hs_gate_out
		&& !s_r.dummy_n)
		else $error("trip did not start dummy time-outs");
	a_dummy_quiet: assert property (s_r.st == BOC_DUMMY |-> !hs_gate_out && !ls_gate_out
		&& ss_ref_out == 6'h00)
		else $error("switching during dummy time-out");
	a_retry_pair: assert property (s_retry_start |-> $past(s_r.dummy_n) && s_r.step == 6'h00
		&& !s_r.sw_on)
		else $error("attempt began before two dummies");
	a_no_resample: assert property (s_r.st == BOC_DUMMY |=> s_r.st != BOC_SAMPLE
		&& !isrc_en_out)
		else $error("retry triggered a new sample");
	a_disable_off: assert property (!enable_in && ce_in |=> s_r.st == BOC_OFF
		&& !hs_gate_out)
		else $error("enable low did not shut down");
	a_resample: assert property (s_r.st == BOC_DELAY ##1 s_r.st == BOC_SAMPLE
		|=> isrc_en_out && !trip.valid)
		else $error("restart did not take fresh sample");
	a_prebias: assert property (s_r.st == BOC_SOFT && !s_r.sw_on |-> !hs_gate_out
		&& !ls_gate_out)
		else $error("switching while output above ramp");
	a_thresh_double: assert property (trip.code < 8'(DETECT_MAX_CODE / 2)
		|-> trip_thresh_out == {trip.code, 1'b0})
		else $error("threshold is not twice the setpoint");

endmodule

// ===== bench/boc_load_model.sv
/*
  Far side model: trip resistor level, output load with pre-bias, and a short.
  Assumes the controller's code and low-side gate are sampled on clk_in.
*/
`timescale 1ns/100ps
module boc_load_model
	import boc_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic [TRIP_W-1:0] code_in,
	input  wire logic [TRIP_W-1:0] setpoint_in,
	input  wire logic              short_in,
	input  wire logic              prebias_in,
	input  wire logic              ls_gate_in,
	output logic                   set_cmp_out,
	output logic                   vout_above_out,
	output logic                   ls_cmp_out
);
	// ----------------------------------------------------------------
	// Comparator levels
	// ----------------------------------------------------------------
	// Levels move just after the edge, like the real comparators
	initial set_cmp_out = 1'b0;
	initial vout_above_out = 1'b0;
	initial ls_cmp_out = 1'b0;
	always @(posedge clk_in) begin
		set_cmp_out    <= (code_in >= setpoint_in);
		vout_above_out <= prebias_in;               // Overcharged output stays high
		ls_cmp_out     <= short_in & ls_gate_in;    // Drop only while the switch conducts
	end
endmodule

// ===== bench/tb_buck_overcurrent_hiccup_ctrl.sv
/*
  Self-checking bench for the overcurrent and start-up controller.
  Assumes shortened timer parameters and the load model on the far side.
*/
`timescale 1ns/100ps
module tb_buck_overcurrent_hiccup_ctrl
	import boc_pkg::*;
;
	localparam int P_DLY = 200;
	logic              clk_in = 1'b0;
	logic              rst_in = 1'b1;
	logic              power_ok_in = 1'b0;
	logic              enable_in = 1'b0;
	logic              pwm_high_in = 1'b0;
	logic              pwm_low_in = 1'b0;
	logic              set_cmp, vout_above, ls_cmp;
	logic              hs_gate_out, ls_gate_out, isrc_en_out;
	logic [5:0]        ss_ref_out;
	logic [TRIP_W-1:0] trip_code_out;
	logic [TRIP_W:0]   trip_thresh_out;
	logic              guard_off_out, hiccup_out, running_out;
	logic [TRIP_W-1:0] setpoint = 8'h14;
	logic              short_on = 1'b0;
	logic              prebias = 1'b0;
	logic              gates_early = 1'b0;
	logic              isrc_seen = 1'b0;
	logic              watch_gates = 1'b0;
	int                hs_width = 100;
	int                pcnt = 0;
	int                miscompares = 0;
	int                compares = 0;

	// ----------------------------------------------------------------
	// Design, far side and clock
	// ----------------------------------------------------------------
	boc_ctrl #(.P_DELAY_CYC(P_DLY), .P_SS_STEP_CYC(4), .P_SAMPLE_STEP(2)) dut (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .power_ok_in(power_ok_in),
		.enable_in(enable_in), .set_cmp_in(set_cmp), .vout_above_in(vout_above),
		.pwm_high_in(pwm_high_in), .pwm_low_in(pwm_low_in), .ls_cmp_in(ls_cmp),
		.hs_gate_out(hs_gate_out), .ls_gate_out(ls_gate_out), .isrc_en_out(isrc_en_out),
		.ss_ref_out(ss_ref_out), .trip_code_out(trip_code_out),
		.trip_thresh_out(trip_thresh_out), .guard_off_out(guard_off_out),
		.hiccup_out(hiccup_out), .running_out(running_out));
	boc_load_model load (.clk_in(clk_in), .code_in(trip_code_out), .setpoint_in(setpoint),
		.short_in(short_on), .prebias_in(prebias), .ls_gate_in(ls_gate_out),
		.set_cmp_out(set_cmp), .vout_above_out(vout_above), .ls_cmp_out(ls_cmp));
	initial forever #4 clk_in = ~clk_in;

	// PWM request at the 208-cycle switching period
	always @(posedge clk_in) begin
		pcnt <= (pcnt == 207) ? 0 : pcnt + 1;
		pwm_high_in <= (pcnt < hs_width);
		pwm_low_in <= (pcnt >= hs_width);
	end

	// Gate and current source watchers
	always @(posedge clk_in) begin
		if (watch_gates && !running_out && (hs_gate_out || ls_gate_out))
			gates_early <= 1'b1;
		if (isrc_en_out)
			isrc_seen <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	function automatic logic pick(input int k);
		case (k)
			0: pick = isrc_en_out;
			1: pick = running_out;
			2: pick = hiccup_out;
			default: pick = ls_gate_out;
		endcase
	endfunction

	// Bounded wait for an output level, counting edges
	task automatic wait_for(input int k, input logic lvl, input int lim, output int n);
		n = 0;
		while (pick(k) !== lvl && n < lim) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		chk($sformatf("wait_%0d", k), {8'h00, lvl}, {8'h00, pick(k)});
	endtask

	task automatic complete_run;
		if (miscompares == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_startup;
		int n;
		@(posedge clk_in);
		power_ok_in <= 1'b1;
		enable_in <= 1'b1;
		wait_for(0, 1'b1, 400, n);
		chk("delay_len", 9'h001, 9'((n >= P_DLY) && (n <= P_DLY + 5))); // delay before sample
		chk("gates_in_sample", 9'h000, {8'h00, hs_gate_out | ls_gate_out}); // low side off
		wait_for(0, 1'b0, 200, n);
		chk("trip_code", 9'h014, {1'b0, trip_code_out}); // held code
		chk("thresh", 9'h028, trip_thresh_out); // doubled setpoint
		chk("guard_off", 9'h000, {8'h00, guard_off_out}); // guard armed
		wait_for(1, 1'b1, 400, n);
		chk("soft_len", 9'h001, 9'((n >= 256) && (n <= 260))); // ramp length
		chk("ss_ref_run", 9'h03f, {3'h0, ss_ref_out}); // top step
	endtask

	task automatic t_stretch;
		int run;
		int best;
		run = 0;
		best = 0;
		hs_width = 207;
		repeat (700) begin
			@(posedge clk_in);
			#1;
			run = ls_gate_out ? run + 1 : 0;
			best = (run > best) ? run : best;
		end
		chk("stretch", 9'h001, 9'(best >= MINLS_CYC)); // third pulse stretched
		hs_width = 100;
	endtask

	task automatic t_hiccup;
		int n;
		isrc_seen = 1'b0;
		short_on = 1'b1;
		wait_for(2, 1'b1, 300, n);
		chk("trip_off", 9'h000, {7'h00, hs_gate_out, running_out}); // output off at once
		wait_for(2, 1'b0, 600, n);
		chk("dummy_len", 16'(DUMMY_COUNT * SS_STEPS * 4), 16'(n)); // two dummy time-outs
		chk("ss_ref_start", 9'h000, {3'h0, ss_ref_out}); // ramp restarts at zero
		wait_for(2, 1'b1, 300, n);
		chk("period", 9'h001, 9'(n <= 256)); // trip in attempt
		wait_for(2, 1'b0, 600, n);
		chk("dummy_len2", 16'(DUMMY_COUNT * SS_STEPS * 4), 16'(n)); // repeats again
		short_on = 1'b0;
		wait_for(1, 1'b1, 800, n); // ramps normally
		chk("no_resample", 9'h000, {8'h00, isrc_seen}); // no new sample
		chk("code_kept", 9'h014, {1'b0, trip_code_out}); // stored setpoint
	endtask

	task automatic t_reenable;
		int n;
		logic bad;
		bad = 1'b0;
		@(posedge clk_in);
		enable_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		#1;
		chk("shutdown", 9'h000, {7'h00, running_out, hs_gate_out}); // held in shutdown
		setpoint = 8'hfa;
		@(posedge clk_in);
		enable_in <= 1'b1;
		wait_for(0, 1'b1, 400, n); // fresh sample
		wait_for(0, 1'b0, 700, n);
		chk("code_cap", 9'h0f0, {1'b0, trip_code_out}); // sample stops at limit
		chk("guard_off", 9'h001, {8'h00, guard_off_out}); // guard disabled
		chk("thresh_cap", 9'd380, trip_thresh_out); // clamped range
		wait_for(1, 1'b1, 800, n);
		short_on = 1'b1;
		repeat (400) begin
			@(posedge clk_in);
			#1;
			bad = bad | hiccup_out;
		end
		chk("no_trip", 9'h000, {8'h00, bad}); // protection off
		short_on = 1'b0;
	endtask

	task automatic t_prebias;
		int n;
		@(posedge clk_in);
		enable_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		#1;
		prebias = 1'b1;
		setpoint = 8'h14;
		gates_early = 1'b0;
		watch_gates = 1'b1;
		@(posedge clk_in);
		enable_in <= 1'b1;
		wait_for(1, 1'b1, 1200, n);
		watch_gates = 1'b0;
		chk("prebias_gates", 9'h000, {8'h00, gates_early}); // switches off in ramp
		wait_for(3, 1'b1, 300, n); // switching at ramp end
		prebias = 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		t_startup();
		t_stretch();
		t_hiccup();
		t_reenable();
		t_prebias();
		complete_run();
	end

	// Cuts a hang well past the expected run
	initial begin
		#400000;
		miscompares++;
		complete_run();
	end
endmodule
